/* core/pm_mailbox_command_port.sv */
// power management controller command port behind an interrupt mailbox
`timescale 1ns/1ns
`default_nettype none
module pm_mailbox_command_port #(
  parameter int   NUM_UNITS      = 4,
  parameter int   UNIT_W         = 2,
  parameter int   CPUS_PER_UNIT  = 2,
  parameter logic DRAM_RETENTION = 1'b0
) (
  // clock and reset
  input  wire logic                                CLK,
  input  wire logic                                SYS_RST,
  // request buffer fill and call interrupt
  input  wire logic                                REQ_WR_EN,
  input  wire logic [pm_mbox_pkg::BUF_AW-1:0]      REQ_WR_ADDR,
  input  wire logic [pm_mbox_pkg::WORD_W-1:0]      REQ_WR_DATA,
  input  wire logic                                IPI_IN,
  input  wire logic [UNIT_W-1:0]                   IPI_IN_SRC,
  // observation
  output logic                                     OBS_BUSY,
  // response and callback buffers
  input  wire logic [pm_mbox_pkg::BUF_AW-1:0]      RESP_RD_ADDR,
  output logic      [pm_mbox_pkg::WORD_W-1:0]      RESP_RD_DATA,
  input  wire logic [pm_mbox_pkg::BUF_AW-1:0]      CB_RD_ADDR,
  output logic      [pm_mbox_pkg::WORD_W-1:0]      CB_RD_DATA,
  output logic      [NUM_UNITS-1:0]                IPI_OUT,
  // power actions
  output logic      [NUM_UNITS-1:0]                SUSPEND_PENDING,
  output logic      [NUM_UNITS*CPUS_PER_UNIT-1:0]  WAKE_CPU,
  input  wire logic                                WARM_RESTART,
  output logic                                     DRAM_SELF_REFRESH
);

  localparam int NCPU = NUM_UNITS * CPUS_PER_UNIT;

  pm_mbox_pkg::ctrl_state_e            state_reg;
  logic [2:0]                          fidx_reg;
  logic [2:0]                          widx_reg;
  logic [UNIT_W-1:0]                   caller_reg;
  logic [pm_mbox_pkg::WORD_W-1:0]      word_reg [0:5];
  logic [pm_mbox_pkg::WORD_W-1:0]      req_rd_data;
  logic [pm_mbox_pkg::WORD_W-1:0]      status_reg;
  logic                                resp_reg;
  logic                                cb_reg;
  logic [pm_mbox_pkg::WORD_W-1:0]      resp_wdata;
  logic [pm_mbox_pkg::WORD_W-1:0]      cb_wdata;
  logic [pm_mbox_pkg::WORD_W-1:0]      exec_status;
  logic                                exec_resp;
  logic                                exec_cb;
  logic                                exec_wake;
  logic [NCPU-1:0]                     exec_wake_vec;
  logic [NUM_UNITS-1:0]                exec_pend_next;
  logic [UNIT_W-1:0]                   tgt_unit;
  logic                                tgt_ok;
  logic                                blocking;
  logic                                resp_we;
  logic                                cb_we;

  // decoding shared by the sequencer and checks
  function automatic logic is_known(input logic [31:0] id);
    is_known = (id == pm_mbox_pkg::CALL_SELF_SUSPEND) ||
               (id == pm_mbox_pkg::CALL_PEER_SUSPEND) ||
               (id == pm_mbox_pkg::CALL_ABORT_SUSPEND) ||
               (id == pm_mbox_pkg::CALL_WAKE);
  endfunction

  function automatic logic [NUM_UNITS-1:0] unit_bit(input logic [UNIT_W-1:0] u);
    unit_bit = {{(NUM_UNITS-1){1'b0}}, 1'b1} << u;
  endfunction

  mbox_word_ram #(.WIDTH(pm_mbox_pkg::WORD_W), .DEPTH(pm_mbox_pkg::BUF_DEPTH),
                  .AW(pm_mbox_pkg::BUF_AW)) u_req_buf (
    .clk     (CLK),
    .wr_en   (REQ_WR_EN && state_reg == pm_mbox_pkg::ST_IDLE),
    .wr_addr (REQ_WR_ADDR),
    .wr_data (REQ_WR_DATA),
    .rd_addr (fidx_reg),
    .rd_data (req_rd_data)
  );

  mbox_word_ram #(.WIDTH(pm_mbox_pkg::WORD_W), .DEPTH(pm_mbox_pkg::BUF_DEPTH),
                  .AW(pm_mbox_pkg::BUF_AW)) u_resp_buf (
    .clk     (CLK),
    .wr_en   (resp_we),
    .wr_addr (widx_reg),
    .wr_data (resp_wdata),
    .rd_addr (RESP_RD_ADDR),
    .rd_data (RESP_RD_DATA)
  );

  mbox_word_ram #(.WIDTH(pm_mbox_pkg::WORD_W), .DEPTH(pm_mbox_pkg::BUF_DEPTH),
                  .AW(pm_mbox_pkg::BUF_AW)) u_cb_buf (
    .clk     (CLK),
    .wr_en   (cb_we),
    .wr_addr (widx_reg),
    .wr_data (cb_wdata),
    .rd_addr (CB_RD_ADDR),
    .rd_data (CB_RD_DATA)
  );

  // busy until the call is handled
  assign OBS_BUSY = (state_reg != pm_mbox_pkg::ST_IDLE);
  assign resp_we  = (state_reg == pm_mbox_pkg::ST_RESP);
  assign cb_we    = (state_reg == pm_mbox_pkg::ST_CB);

  // sequencer
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      state_reg  <= pm_mbox_pkg::ST_IDLE;
      fidx_reg   <= 3'h0;
      widx_reg   <= 3'h0;
      caller_reg <= '0;
    end else begin
      case (state_reg)
        pm_mbox_pkg::ST_IDLE: begin
          // new calls taken only when idle
          if (IPI_IN) begin
            state_reg  <= pm_mbox_pkg::ST_FETCH;
            caller_reg <= IPI_IN_SRC;
            fidx_reg   <= 3'h0;
          end
        end
        pm_mbox_pkg::ST_FETCH: begin
          fidx_reg <= fidx_reg + 3'h1;
          if (fidx_reg == pm_mbox_pkg::REQ_DONE) begin
            state_reg <= pm_mbox_pkg::ST_EXEC;
          end
        end
        pm_mbox_pkg::ST_EXEC: begin
          widx_reg <= 3'h0;
          if (exec_resp) begin
            state_reg <= pm_mbox_pkg::ST_RESP;
          end else if (exec_cb) begin
            state_reg <= pm_mbox_pkg::ST_CB;
          end else begin
            state_reg <= pm_mbox_pkg::ST_DONE;
          end
        end
        pm_mbox_pkg::ST_RESP: begin
          widx_reg <= widx_reg + 3'h1;
          if (widx_reg == pm_mbox_pkg::RESP_LAST) begin
            widx_reg  <= 3'h0;
            state_reg <= cb_reg ? pm_mbox_pkg::ST_CB : pm_mbox_pkg::ST_DONE;
          end
        end
        pm_mbox_pkg::ST_CB: begin
          widx_reg <= widx_reg + 3'h1;
          if (widx_reg == pm_mbox_pkg::CB_LAST) begin
            state_reg <= pm_mbox_pkg::ST_DONE;
          end
        end
        pm_mbox_pkg::ST_DONE: begin
          state_reg <= pm_mbox_pkg::ST_IDLE;
        end
        default: begin
          state_reg <= pm_mbox_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // word k lands one cycle after its read address
  always_ff @(posedge CLK) begin
    if (state_reg == pm_mbox_pkg::ST_FETCH && fidx_reg != 3'h0) begin
      word_reg[fidx_reg - 3'h1] <= req_rd_data;
    end
  end

  assign tgt_unit = word_reg[pm_mbox_pkg::W_TARGET][pm_mbox_pkg::NODE_UNIT_LSB +: UNIT_W];
  assign tgt_ok   = (int'(tgt_unit) < NUM_UNITS);
  assign blocking = (word_reg[pm_mbox_pkg::W_ACK] == pm_mbox_pkg::ACK_BLOCKING);

  // call decode
  always_comb begin
    int cpu;
    int idx;
    cpu            = 0;
    idx            = 0;
    exec_status    = pm_mbox_pkg::STATUS_OK;
    exec_resp      = 1'b0;
    exec_cb        = 1'b0;
    exec_wake      = 1'b0;
    exec_wake_vec  = '0;
    exec_pend_next = SUSPEND_PENDING;
    case (word_reg[pm_mbox_pkg::W_ID])
      pm_mbox_pkg::CALL_PEER_SUSPEND: begin
        exec_resp = blocking;
        // init suspend callback to the target
        if (tgt_ok) begin
          exec_cb = 1'b1;
          exec_pend_next = SUSPEND_PENDING | unit_bit(tgt_unit);
        end else begin
          exec_status = pm_mbox_pkg::STATUS_ERR_ARG;
        end
      end
      pm_mbox_pkg::CALL_WAKE: begin
        exec_resp = blocking;
        // whole unit wakes its primary cpu only
        if (word_reg[pm_mbox_pkg::W_TARGET][pm_mbox_pkg::NODE_WHOLE_BIT]) begin
          cpu = 0;
        end else begin
          cpu = int'(word_reg[pm_mbox_pkg::W_TARGET][pm_mbox_pkg::NODE_CPU_LSB +: 4]);
        end
        idx = int'(tgt_unit) * CPUS_PER_UNIT + cpu;
        if (tgt_ok && cpu < CPUS_PER_UNIT) begin
          exec_wake = 1'b1;
          exec_wake_vec[idx] = 1'b1;
        end else begin
          exec_status = pm_mbox_pkg::STATUS_ERR_ARG;
        end
      end
      // abort or own suspend ends the pending request
      pm_mbox_pkg::CALL_ABORT_SUSPEND,
      pm_mbox_pkg::CALL_SELF_SUSPEND: begin
        exec_pend_next = SUSPEND_PENDING & ~unit_bit(caller_reg);
      end
      default: begin
        exec_status = pm_mbox_pkg::STATUS_ERR_CALL;
        exec_resp   = 1'b1;
      end
    endcase
  end

  // results latched at execution
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      status_reg <= pm_mbox_pkg::STATUS_OK;
      resp_reg   <= 1'b0;
      cb_reg     <= 1'b0;
    end else if (state_reg == pm_mbox_pkg::ST_EXEC) begin
      status_reg <= exec_status;
      resp_reg   <= exec_resp;
      cb_reg     <= exec_cb;
    end
  end

  // power state effects
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      SUSPEND_PENDING <= '0;
      WAKE_CPU        <= '0;
    end else begin
      WAKE_CPU <= '0;
      if (state_reg == pm_mbox_pkg::ST_EXEC) begin
        SUSPEND_PENDING <= exec_pend_next;
        if (exec_wake) begin
          WAKE_CPU <= exec_wake_vec;
        end
      end
    end
  end

  always_comb begin
    resp_wdata = '0;
    if (widx_reg == pm_mbox_pkg::W_ID) begin
      resp_wdata = (state_reg == pm_mbox_pkg::ST_EXEC) ? exec_status : status_reg;
    end else if (widx_reg == pm_mbox_pkg::W_VALUE1) begin
      resp_wdata = word_reg[pm_mbox_pkg::W_TARGET];
    end
  end

  always_comb begin
    cb_wdata = '0;
    if (widx_reg == pm_mbox_pkg::W_ID) begin
      cb_wdata = pm_mbox_pkg::CB_INIT_SUSPEND;
    end else if (widx_reg == pm_mbox_pkg::W_REASON) begin
      cb_wdata = pm_mbox_pkg::REASON_PU_REQ;
    end else if (widx_reg == pm_mbox_pkg::W_ACK) begin
      cb_wdata = word_reg[pm_mbox_pkg::W_LATENCY];
    end else if (widx_reg == pm_mbox_pkg::W_LATENCY) begin
      cb_wdata = word_reg[pm_mbox_pkg::W_STATE];
    end
  end

  // interrupt follows the last buffer write
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      IPI_OUT <= '0;
    end else begin
      IPI_OUT <= '0;
      if (resp_we && widx_reg == pm_mbox_pkg::RESP_LAST) begin
        IPI_OUT <= unit_bit(caller_reg);
      end else if (cb_we && widx_reg == pm_mbox_pkg::CB_LAST) begin
        IPI_OUT <= unit_bit(tgt_unit);
      end
    end
  end

  // self-refresh while a warm restart lasts
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      DRAM_SELF_REFRESH <= 1'b0;
    end else begin
      DRAM_SELF_REFRESH <= DRAM_RETENTION && WARM_RESTART;
    end
  end

  default clocking cb_main @(posedge CLK); endclocking
  default disable iff (SYS_RST);

  AST_FETCH_SIX: assert property (
    (state_reg == pm_mbox_pkg::ST_IDLE && IPI_IN) |=>
      (state_reg == pm_mbox_pkg::ST_FETCH) [*7] ##1 (state_reg == pm_mbox_pkg::ST_EXEC))
    else $error("request fetch did not take six words");

  AST_BUSY_SPAN: assert property (
    (state_reg == pm_mbox_pkg::ST_IDLE && IPI_IN) |=> OBS_BUSY [*8])
    else $error("busy dropped during a call");

  AST_RESP_RANGE: assert property (
    resp_we |-> (widx_reg <= pm_mbox_pkg::RESP_LAST))
    else $error("response written beyond word 3");

  AST_CB_ID_WORD: assert property (
    (cb_we && !$past(cb_we)) |-> (widx_reg == pm_mbox_pkg::W_ID) &&
      (cb_wdata == pm_mbox_pkg::CB_INIT_SUSPEND))
    else $error("callback does not open with its id in word 0");

  AST_IPI_AFTER_WRITE: assert property (
    (IPI_OUT != '0) |-> $onehot(IPI_OUT) &&
      ($past(resp_we && widx_reg == pm_mbox_pkg::RESP_LAST) ||
       $past(cb_we && widx_reg == pm_mbox_pkg::CB_LAST)))
    else $error("interrupt raised without a finished buffer write");

  AST_PEER_CALLBACK: assert property (
    (state_reg == pm_mbox_pkg::ST_EXEC && exec_cb) |-> ##[5:11] (IPI_OUT == unit_bit(tgt_unit)))
    else $error("peer suspend gave no callback interrupt");

  AST_WAKE_ONE: assert property (
    (WAKE_CPU != '0) |-> $onehot(WAKE_CPU) && $past(state_reg == pm_mbox_pkg::ST_EXEC))
    else $error("more than one cpu woken");

  AST_DRAM_SR: assert property (
    DRAM_SELF_REFRESH |-> (DRAM_RETENTION && $past(WARM_RESTART)))
    else $error("dram self-refresh without option and restart");

  AST_UNKNOWN_CALL: assert property (
    (state_reg == pm_mbox_pkg::ST_EXEC && !is_known(word_reg[pm_mbox_pkg::W_ID])) |=>
      $stable(SUSPEND_PENDING) && (WAKE_CPU == '0) &&
      (status_reg == pm_mbox_pkg::STATUS_ERR_CALL) && resp_we)
    else $error("unknown call changed state or gave no error");

  AST_ACK_BLOCKING: assert property (
    (state_reg == pm_mbox_pkg::ST_EXEC && is_known(word_reg[pm_mbox_pkg::W_ID])) |=>
      (resp_we == $past(exec_resp)))
    else $error("acknowledge does not match the call");

endmodule
`default_nettype wire

/* core/pm_mbox_pkg.sv */
// constants shared by the power management command port and its buffers
package pm_mbox_pkg;

  // buffer geometry
  localparam int       WORD_W     = 32;
  localparam int       BUF_AW     = 3;
  localparam int       BUF_DEPTH  = 8;
  localparam logic [2:0] REQ_LAST  = 3'h5;
  localparam logic [2:0] REQ_DONE  = 3'h6;
  localparam logic [2:0] RESP_LAST = 3'h3;
  localparam logic [2:0] CB_LAST   = 3'h5;

  // word positions inside a request, response or callback
  localparam logic [2:0] W_ID      = 3'h0;
  localparam logic [2:0] W_TARGET  = 3'h1;
  localparam logic [2:0] W_ACK     = 3'h2;
  localparam logic [2:0] W_LATENCY = 3'h3;
  localparam logic [2:0] W_STATE   = 3'h4;
  localparam logic [2:0] W_REASON  = 3'h1;
  localparam logic [2:0] W_VALUE1  = 3'h1;

  // call identifiers (arbitrary encodings)
  localparam logic [31:0] CALL_SELF_SUSPEND  = 32'h0000_000a;
  localparam logic [31:0] CALL_PEER_SUSPEND  = 32'h0000_000b;
  localparam logic [31:0] CALL_ABORT_SUSPEND = 32'h0000_000c;
  localparam logic [31:0] CALL_WAKE          = 32'h0000_000d;
  localparam logic [31:0] CB_INIT_SUSPEND    = 32'h0000_001e;

  // acknowledge modes carried in word 2
  localparam logic [31:0] ACK_NO       = 32'h0000_0001;
  localparam logic [31:0] ACK_BLOCKING = 32'h0000_0002;

  // status codes and callback reason
  localparam logic [31:0] STATUS_OK       = 32'h0000_0000;
  localparam logic [31:0] STATUS_ERR_CALL = 32'h0000_0001;
  localparam logic [31:0] STATUS_ERR_ARG  = 32'h0000_0002;
  localparam logic [31:0] REASON_PU_REQ   = 32'h0000_0001;

  // node word layout
  localparam int NODE_UNIT_LSB  = 0;
  localparam int NODE_CPU_LSB   = 4;
  localparam int NODE_WHOLE_BIT = 8;

  // controller sequencing, one-hot
  typedef enum logic [5:0] {
    ST_IDLE  = 6'h01,
    ST_FETCH = 6'h02,
    ST_EXEC  = 6'h04,
    ST_RESP  = 6'h08,
    ST_CB    = 6'h10,
    ST_DONE  = 6'h20
  } ctrl_state_e;

endpackage

/* core/mbox_word_ram.sv */
// small mailbox word buffer with one write port and a registered read port
`timescale 1ns/1ns
`default_nettype none
module mbox_word_ram #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8,
  parameter int AW    = 3
) (
  // clock
  input  wire logic             clk,
  // write side
  input  wire logic             wr_en,
  input  wire logic [AW-1:0]    wr_addr,
  input  wire logic [WIDTH-1:0] wr_data,
  // read side
  input  wire logic [AW-1:0]    rd_addr,
  output logic      [WIDTH-1:0] rd_data
);

  logic [WIDTH-1:0] mem [0:DEPTH-1];

  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clk) begin
    rd_data <= mem[rd_addr];
  end

endmodule
`default_nettype wire

/* sim/pu_caller_model.sv */
// processing unit model that issues calls and watches the controller
`timescale 1ns/1ns
`default_nettype none
module pu_caller_model (
  // clock
  input  wire logic        clk,
  // request side
  output logic             req_wr_en,
  output logic [2:0]       req_wr_addr,
  output logic [31:0]      req_wr_data,
  output logic             ipi_in,
  output logic [1:0]       ipi_in_src,
  // answer side
  input  wire logic        obs_busy,
  output logic [2:0]       resp_rd_addr,
  input  wire logic [31:0] resp_rd_data,
  output logic [2:0]       cb_rd_addr,
  input  wire logic [31:0] cb_rd_data,
  input  wire logic [3:0]  ipi_out
);
  int          busy_cnt;
  int          ipi_cnt;
  logic [3:0]  ipi_or;
  logic [31:0] cb_at_irq;
  logic        done_ok;

  initial begin
    req_wr_en    = 1'b0;
    req_wr_addr  = 3'h0;
    req_wr_data  = 32'h0;
    ipi_in       = 1'b0;
    ipi_in_src   = 2'h0;
    resp_rd_addr = 3'h0;
    cb_rd_addr   = 3'h0;
    busy_cnt     = 0;
    ipi_cnt      = 0;
    ipi_or       = 4'h0;
    cb_at_irq    = 32'h0;
    done_ok      = 1'b0;
  end

  // watch busy time and incoming interrupts
  always @(posedge clk) begin
    if (obs_busy === 1'b1) begin
      busy_cnt <= busy_cnt + 1;
    end
    if (ipi_out !== 4'h0) begin
      ipi_cnt   <= ipi_cnt + 1;
      ipi_or    <= ipi_or | ipi_out;
      cb_at_irq <= cb_rd_data;
    end
  end

  // fill the request buffer, raise the call interrupt, wait for completion
  task automatic issue(input logic [1:0] src, input logic [31:0] w [6]);
    int n;
    // six 32-bit words from offset zero
    for (int i = 0; i < 6; i++) begin
      @(posedge clk);
      #1;
      req_wr_en   = 1'b1;
      req_wr_addr = 3'(i);
      req_wr_data = w[i];
    end
    @(posedge clk);
    #1;
    req_wr_en   = 1'b0;
    req_wr_data = ~req_wr_data;
    ipi_in      = 1'b1;
    ipi_in_src  = src;
    busy_cnt    = 0;
    ipi_cnt     = 0;
    ipi_or      = 4'h0;
    @(posedge clk);
    #1;
    ipi_in     = 1'b0;
    ipi_in_src = ~src;
    n       = 0;
    done_ok = 1'b0;
    while (n < 60 && !done_ok) begin
      @(posedge clk);
      #1;
      n++;
      if (obs_busy === 1'b0) begin
        done_ok = 1'b1;
      end
    end
  endtask

  // buffers are read only once the call is complete
  task automatic read_word(input logic cb, input logic [2:0] a, output logic [31:0] d);
    @(posedge clk);
    #1;
    if (cb) begin
      cb_rd_addr = a;
    end else begin
      resp_rd_addr = a;
    end
    @(posedge clk);
    #1;
    d = cb ? cb_rd_data : resp_rd_data;
  endtask
endmodule
`default_nettype wire

/* sim/tb_top.sv */
// self-checking bench for the power management command port
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic        clk;
  logic        rst;
  logic        warm;
  logic        dram;
  logic        req_wr_en;
  logic        ipi_in;
  logic        obs_busy;
  logic [1:0]  ipi_in_src;
  logic [2:0]  req_wr_addr;
  logic [2:0]  resp_rd_addr;
  logic [2:0]  cb_rd_addr;
  logic [31:0] req_wr_data;
  logic [31:0] resp_rd_data;
  logic [31:0] cb_rd_data;
  logic [3:0]  ipi_out;
  logic [3:0]  pend;
  logic [7:0]  wake;
  logic [7:0]  wake_or;
  logic [31:0] w [6];
  logic [31:0] e [6];
  logic [31:0] d;
  int          miscompares;
  int          n_tests;
  int          cycles;
  int          wake_cnt;

  pm_mailbox_command_port #(.DRAM_RETENTION(1'b1)) dut (
    .CLK(clk), .SYS_RST(rst), .REQ_WR_EN(req_wr_en), .REQ_WR_ADDR(req_wr_addr),
    .REQ_WR_DATA(req_wr_data), .IPI_IN(ipi_in), .IPI_IN_SRC(ipi_in_src),
    .OBS_BUSY(obs_busy), .RESP_RD_ADDR(resp_rd_addr), .RESP_RD_DATA(resp_rd_data),
    .CB_RD_ADDR(cb_rd_addr), .CB_RD_DATA(cb_rd_data), .IPI_OUT(ipi_out),
    .SUSPEND_PENDING(pend), .WAKE_CPU(wake), .WARM_RESTART(warm),
    .DRAM_SELF_REFRESH(dram));

  pu_caller_model pu (
    .clk(clk), .req_wr_en(req_wr_en), .req_wr_addr(req_wr_addr),
    .req_wr_data(req_wr_data), .ipi_in(ipi_in), .ipi_in_src(ipi_in_src),
    .obs_busy(obs_busy), .resp_rd_addr(resp_rd_addr), .resp_rd_data(resp_rd_data),
    .cb_rd_addr(cb_rd_addr), .cb_rd_data(cb_rd_data), .ipi_out(ipi_out));

  always #20 clk = ~clk;

  // wake pulse watch and run ceiling
  always @(posedge clk) begin
    cycles++;
    if (wake !== 8'h00) begin
      wake_cnt++;
      wake_or = wake_or | wake;
    end
    if (cycles >= 2000) begin
      miscompares++;
      report_and_stop();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic run_call(input logic [1:0] src, input int busy);
    wake_cnt = 0;
    wake_or  = 8'h00;
    pu.issue(src, w);
    chk({31'h0, pu.done_ok}, 32'h1);
    chk(32'(pu.busy_cnt), 32'(busy));
  endtask

  task automatic t_peer;
    w = '{pm_mbox_pkg::CALL_PEER_SUSPEND, 32'h3, pm_mbox_pkg::ACK_NO, 32'h64, 32'h7, 32'h0};
    e = '{pm_mbox_pkg::CB_INIT_SUSPEND, pm_mbox_pkg::REASON_PU_REQ, 32'h64, 32'h7, 32'h0, 32'h0};
    run_call(2'h0, 15);
    chk({28'h0, pu.ipi_or}, 32'h8);
    chk(32'(pu.ipi_cnt), 32'h1);
    chk(pu.cb_at_irq, pm_mbox_pkg::CB_INIT_SUSPEND);
    chk({28'h0, pend}, 32'h8);
    for (int i = 0; i < 6; i++) begin
      pu.read_word(1'b1, 3'(i), d);
      chk(d, e[i]);
    end
    $display("test peer_suspend done");
  endtask

  task automatic t_unknown;
    w = '{32'h55, 32'h3, pm_mbox_pkg::ACK_BLOCKING, 32'h0, 32'h0, 32'h0};
    run_call(2'h1, 13);
    chk({28'h0, pu.ipi_or}, 32'h2);
    chk({28'h0, pend}, 32'h8);
    chk(32'(wake_cnt), 32'h0);
    pu.read_word(1'b0, 3'h0, d);
    chk(d, pm_mbox_pkg::STATUS_ERR_CALL);
    $display("test unknown_call done");
  endtask

  task automatic t_wake_unit;
    w = '{pm_mbox_pkg::CALL_WAKE, 32'h102, pm_mbox_pkg::ACK_BLOCKING, 32'h0, 32'h0, 32'h0};
    e = '{pm_mbox_pkg::STATUS_OK, 32'h102, 32'h0, 32'h0, 32'h0, 32'h0};
    run_call(2'h1, 13);
    chk({24'h0, wake_or}, 32'h10);
    chk(32'(wake_cnt), 32'h1);
    chk({28'h0, pu.ipi_or}, 32'h2);
    for (int i = 0; i < 4; i++) begin
      pu.read_word(1'b0, 3'(i), d);
      chk(d, e[i]);
    end
    $display("test wake_unit done");
  endtask

  task automatic t_wake_cpu;
    w = '{pm_mbox_pkg::CALL_WAKE, 32'h11, pm_mbox_pkg::ACK_NO, 32'h0, 32'h0, 32'h0};
    run_call(2'h0, 9);
    chk({24'h0, wake_or}, 32'h08);
    chk({28'h0, pu.ipi_or}, 32'h0);
    $display("test wake_cpu done");
  endtask

  task automatic t_abort;
    w = '{pm_mbox_pkg::CALL_ABORT_SUSPEND, 32'h1, pm_mbox_pkg::ACK_NO, 32'h0, 32'h0, 32'h0};
    run_call(2'h3, 9);
    chk({28'h0, pend}, 32'h0);
    chk({28'h0, pu.ipi_or}, 32'h0);
    $display("test abort done");
  endtask

  task automatic t_dram;
    @(posedge clk);
    #1;
    warm = 1'b1;
    chk({31'h0, dram}, 32'h0);
    @(posedge clk);
    #1;
    chk({31'h0, dram}, 32'h1);
    warm = 1'b0;
    @(posedge clk);
    #1;
    chk({31'h0, dram}, 32'h0);
    $display("test dram_retention done");
  endtask

  task automatic t_peer_ack;
    w = '{pm_mbox_pkg::CALL_PEER_SUSPEND, 32'h2, pm_mbox_pkg::ACK_BLOCKING, 32'h10, 32'h3, 32'h0};
    run_call(2'h0, 19);
    chk({28'h0, pu.ipi_or}, 32'h5);
    chk(32'(pu.ipi_cnt), 32'h2);
    chk({28'h0, pend}, 32'h4);
    pu.read_word(1'b0, 3'h0, d);
    chk(d, pm_mbox_pkg::STATUS_OK);
    pu.read_word(1'b1, 3'h2, d);
    chk(d, 32'h10);
    $display("test peer_suspend_ack done");
  endtask

  task automatic t_self;
    w = '{pm_mbox_pkg::CALL_SELF_SUSPEND, 32'h2, pm_mbox_pkg::ACK_NO, 32'h0, 32'h0, 32'h0};
    run_call(2'h2, 9);
    chk({28'h0, pend}, 32'h0);
    chk({28'h0, pu.ipi_or}, 32'h0);
    $display("test self_suspend done");
  endtask

  task automatic t_bad_wake;
    w = '{pm_mbox_pkg::CALL_WAKE, 32'h31, pm_mbox_pkg::ACK_BLOCKING, 32'h0, 32'h0, 32'h0};
    run_call(2'h1, 13);
    chk(32'(wake_cnt), 32'h0);
    chk({28'h0, pu.ipi_or}, 32'h2);
    pu.read_word(1'b0, 3'h0, d);
    chk(d, pm_mbox_pkg::STATUS_ERR_ARG);
    $display("test bad_wake done");
  endtask

  task automatic report_and_stop;
    $display("checks=%0d mismatches=%0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    clk         = 1'b0;
    rst         = 1'b1;
    warm        = 1'b0;
    miscompares = 0;
    n_tests     = 0;
    cycles      = 0;
    wake_cnt    = 0;
    wake_or     = 8'h00;
    repeat (3) @(posedge clk);
    #1;
    rst = 1'b0;
    chk({27'h0, pend, obs_busy}, 32'h0);
    t_peer();
    t_unknown();
    t_wake_unit();
    t_wake_cpu();
    t_abort();
    t_peer_ack();
    t_self();
    t_bad_wake();
    t_dram();
    report_and_stop();
  end
endmodule
`default_nettype wire
